// *** dv/thmo_switches.sv ***
// file: model of the two-hand switches that feed both evaluators
module thmo_switches (
    input wire logic [1:0] eq_press,
    input wire logic [1:0] cp_press,
    input wire logic [1:0] cp_stick,
    output logic eq_in_a,
    output logic eq_in_b,
    output logic cp_in_1a,
    output logic cp_in_1b,
    output logic cp_in_2a,
    output logic cp_in_2b
);
    timeunit 1ns;
    timeprecision 1ps;
    // equivalent pair: two make contacts, one per channel
    assign eq_in_a = eq_press[0];
    assign eq_in_b = eq_press[1];
    // complementary pairs: make plus break contact, a welded break contact stays closed
    assign cp_in_1a = cp_press[0];
    assign cp_in_1b = ~cp_press[0] | cp_stick[0];
    assign cp_in_2a = cp_press[1];
    assign cp_in_2b = ~cp_press[1] | cp_stick[1];
endmodule : thmo_switches

// *** dv/thmo_top_test.sv ***
// file: self-checking bench for the two-hand and multi-operator block
module thmo_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    // short logic cycle keeps the 500 ms windows cheap: 50 ticks of 4 clocks
    localparam int TK = 4;
    typedef struct {logic k; logic [32:0] m; logic [32:0] v;} thmo_note_t;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] eq_press = 2'b00;
    logic [1:0] cp_press = 2'b00;
    logic [1:0] cp_stick = 2'b00;
    logic eq_in_a, eq_in_b, cp_in_1a, cp_in_1b, cp_in_2a, cp_in_2b;
    logic [2:0] op_in = 3'b000;
    logic [1:0] rel_in = 2'b00;
    logic cyc_req = 1'b0;
    logic eq_enable, eq_disc_err, eq_fault, cp_enable, cp_disc_err1, cp_disc_err2;
    logic cp_fault, mo_enable, irq;
    logic [8:0] outs;
    thmo_note_t notes[$];
    thmo_note_t nt;
    int n_errors = 0;
    int checks_done = 0;
    logic rb;

    always #4 clk_sys = ~clk_sys;
    assign outs = {eq_enable, eq_disc_err, eq_fault, cp_enable, cp_disc_err1, cp_disc_err2,
        cp_fault, mo_enable, irq};

    thmo_switches u_sw (.eq_press(eq_press), .cp_press(cp_press), .cp_stick(cp_stick),
        .eq_in_a(eq_in_a), .eq_in_b(eq_in_b), .cp_in_1a(cp_in_1a), .cp_in_1b(cp_in_1b),
        .cp_in_2a(cp_in_2a), .cp_in_2b(cp_in_2b));

    thmo_top #(.TICK_CYC(TK)) u_dut (.clk_sys(clk_sys), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .eq_in_a(eq_in_a), .eq_in_b(eq_in_b),
        .cp_in_1a(cp_in_1a), .cp_in_1b(cp_in_1b), .cp_in_2a(cp_in_2a), .cp_in_2b(cp_in_2b),
        .op_in(op_in), .rel_in(rel_in), .cyc_req(cyc_req), .eq_enable(eq_enable),
        .eq_disc_err(eq_disc_err), .eq_fault(eq_fault), .cp_enable(cp_enable),
        .cp_disc_err1(cp_disc_err1), .cp_disc_err2(cp_disc_err2), .cp_fault(cp_fault),
        .mo_enable(mo_enable), .irq(irq));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out;
        // a note still waiting means an expected result never appeared
        if (notes.size() != 0)
            n_errors++;
        if (n_errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out

    task automatic tk(input int n);
        repeat (n * TK) @(posedge clk_sys);
    endtask : tk

    // note for the output watcher, pushed two edges on so registered outputs have settled
    task automatic eo(input logic [8:0] m, input logic [8:0] v);
        repeat (2) @(posedge clk_sys);
        notes.push_back('{1'b1, {24'h00_0000, m}, {24'h00_0000, v}});
    endtask : eo

    // one apb transfer; reads note the expected data under a mask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [31:0] m, input logic err);
        notes.push_back('{1'b0, {1'b1, w ? 32'h0 : m}, {err, w ? 32'h0 : d & m}});
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (int i = 0; i < 50; i++)
        begin
            @(posedge clk_sys);
            if (pready === 1'b1)
                break;
        end
        if (pready !== 1'b1)
            n_errors++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // watcher: apb notes wait for pready, output notes take the next edge
    always @(posedge clk_sys)
    begin
        if (notes.size() > 0 && (notes[0].k || pready === 1'b1))
        begin
            nt = notes.pop_front();
            check((nt.k ? {24'h00_0000, outs} : {pslverr, prdata}) & nt.m, nt.v);
        end
    end

    // watchdog: whole run is about a thousand clocks
    initial
    begin
        repeat (30000) @(posedge clk_sys);
        n_errors++;
        close_out();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        void'($urandom(32'h3df6affc));
        repeat (2) @(posedge clk_sys);
        eo(9'h1ff, 9'h000);
        @(posedge clk_sys);
        srst <= 1'b0;
        apb(1'b0, thmo_pkg::ADDR_CTRL, 32'h0000_0000, 32'hffff_ffff, 1'b0);
        apb(1'b0, 8'h20, 32'h0000_0000, 32'hffff_ffff, 1'b1);
        apb(1'b1, thmo_pkg::ADDR_DISC, 32'h0000_0505, 32'hffff_ffff, 1'b0);
        apb(1'b1, thmo_pkg::ADDR_MASK, 32'h0000_000f, 32'hffff_ffff, 1'b0);
        rel_in <= 2'b11;
        // run, eq error and fault, three cp outputs, cp fault, 3 operators, 2 releases
        apb(1'b1, thmo_pkg::ADDR_CTRL, 32'h0000_0177, 32'hffff_ffff, 1'b0);
        apb(1'b0, thmo_pkg::ADDR_CTRL, 32'h0000_0177, 32'hffff_ffff, 1'b0);
        apb(1'b0, thmo_pkg::ADDR_DISC, 32'h0000_0505, 32'hffff_ffff, 1'b0);
        // equivalent pair: second hand late but inside the limit
        eq_press <= 2'b01;
        tk($urandom_range(40, 1));
        eq_press <= 2'b11;
        tk(3);
        eo(9'h1c0, 9'h100);
        eq_press <= 2'b00;
        tk(3);
        eo(9'h1c0, 9'h000);
        // second hand never follows: error, fault and interrupt
        eq_press <= 2'b10;
        tk(55);
        eo(9'h1c1, 9'h0c1);
        apb(1'b0, thmo_pkg::ADDR_STAT, 32'h0000_0004, 32'h0000_00fc, 1'b0);
        apb(1'b1, thmo_pkg::ADDR_MASK, 32'h0000_0000, 32'hffff_ffff, 1'b0);
        eo(9'h001, 9'h000);
        apb(1'b1, thmo_pkg::ADDR_MASK, 32'h0000_000f, 32'hffff_ffff, 1'b0);
        eo(9'h001, 9'h001);
        eq_press <= 2'b00;
        tk(3);
        eo(9'h0c0, 9'h000);
        apb(1'b0, thmo_pkg::ADDR_IRQ, 32'h0000_0001, 32'h0000_000f, 1'b0);
        apb(1'b0, thmo_pkg::ADDR_IRQ, 32'h0000_0000, 32'h0000_000f, 1'b0);
        eo(9'h001, 9'h000);
        // complementary: both hands together, then release to inactive
        cp_press <= 2'b11;
        tk(3);
        eo(9'h03c, 9'h020);
        cp_press <= 2'b00;
        tk(3);
        eo(9'h020, 9'h000);
        // second hand beyond the window: no enable and no error flag
        cp_press <= 2'b01;
        tk(60);
        cp_press <= 2'b11;
        tk(3);
        eo(9'h03c, 9'h000);
        cp_press <= 2'b00;
        tk(3);
        // welded break contact on pair 1, limit is 5 ticks
        cp_stick <= 2'b01;
        cp_press <= 2'b01;
        tk(2);
        eo(9'h01c, 9'h000);
        tk(6);
        eo(9'h01c, 9'h014);
        cp_stick <= 2'b00;
        cp_press <= 2'b00;
        // after a clean release the next actuation enables and clears the errors
        tk(3);
        cp_press <= 2'b11;
        tk(3);
        eo(9'h03c, 9'h020);
        cp_press <= 2'b00;
        // multi operator: all released since run, then all pressed
        op_in <= 3'b111;
        tk(3);
        eo(9'h002, 9'h002);
        op_in <= 3'b110;
        tk(3);
        eo(9'h002, 9'h000);
        op_in <= 3'b111;
        tk(3);
        eo(9'h002, 9'h002);
        rel_in <= 2'b01;
        tk(3);
        eo(9'h002, 9'h000);
        rel_in <= 2'b11;
        op_in <= 3'b000;
        tk(3);
        op_in <= 3'b111;
        tk(3);
        eo(9'h002, 9'h002);
        cyc_req <= 1'b1;
        tk(2);
        cyc_req <= 1'b0;
        tk(1);
        eo(9'h002, 9'h000);
        apb(1'b0, thmo_pkg::ADDR_IRQ, 32'h0000_0008, 32'h0000_0008, 1'b0);
        op_in <= 3'b110;
        tk(3);
        op_in <= 3'b111;
        tk(3);
        eo(9'h002, 9'h000);
        op_in <= 3'b000;
        tk(3);
        op_in <= 3'b111;
        tk(3);
        eo(9'h002, 9'h002);
        // stop, switch to two operators, run again: re-arm needed
        apb(1'b1, thmo_pkg::ADDR_CTRL, 32'h0000_0136, 32'hffff_ffff, 1'b0);
        tk(3);
        eo(9'h002, 9'h000);
        apb(1'b1, thmo_pkg::ADDR_CTRL, 32'h0000_0137, 32'hffff_ffff, 1'b0);
        tk(3);
        eo(9'h002, 9'h000);
        op_in <= 3'b000;
        tk(3);
        rb = 1'($urandom_range(1, 0));
        op_in <= {rb, 2'b11};
        tk(3);
        eo(9'h002, 9'h002);
        tk(1);
        close_out();
    end
endmodule : thmo_top_test

// *** src/thmo_pkg.sv ***
// package: constants for the two-hand and multi-operator safety block
package thmo_pkg;
    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_DISC = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ = 8'h0C;
    localparam logic [7:0] ADDR_MASK = 8'h10;
    // ctrl field positions
    localparam int CTRL_RUN = 0;
    localparam int CTRL_EQ_NOUT = 1;
    localparam int CTRL_EQ_FLT = 2;
    localparam int CTRL_CP_NOUT0 = 3;
    localparam int CTRL_CP_FLT = 5;
    localparam int CTRL_OPS3 = 6;
    localparam int CTRL_NREL0 = 7;
    localparam int CTRL_CYC_FALL = 9;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // discrepancy times in 10 ms steps, pair 1 bits 5:0, pair 2 bits 13:8
    localparam logic [31:0] DISC_RESET = 32'h0000_0000;
    localparam int DISC_MAX_STEPS = 50;
    // irq and mask bit positions; status holds the error flags two bits higher
    localparam int EV_EQ_DISC = 0;
    localparam int EV_CP_DISC1 = 1;
    localparam int EV_CP_DISC2 = 2;
    localparam int EV_CYC = 3;
    localparam int NEV = 4;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int TICK_MS = 10;
    localparam int LIMIT_MS = 500;
    localparam int TICK_CYCLES = TICK_MS * 1000 * CLK_MHZ;
    localparam int LIMIT_TICKS = LIMIT_MS / TICK_MS;
endpackage : thmo_pkg

// *** src/thmo_top.sv ***
// module: two-hand evaluators and multi-operator combiner with apb registers
// Functional notes
// - equivalent pair must agree, enable when high
// - equivalent discrepancy limit fixed at 500 ms
// - equivalent outputs: enable, optional error, fault
// - complementary two pairs, open and closed contacts
// - per pair discrepancy 0 off, 10-500 ms; the field takes up to 63 steps (630 ms), not clamped to 50
// - complementary outputs one, two or three
// - both pairs actuated within 500 ms window
// - sync inactive only when both pairs inactive
// - window overrun gives no error, enable low
// - combiner uses two or three operators
// - zero to two static releases must hold
// - each operator released once before enable
// - stop to run re-arms release requirement
// - cycle request edge drops enable, re-arms
// - enable falls when release or operator low
module thmo_top #(
    parameter int TICK_CYC = thmo_pkg::TICK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic eq_in_a,
    input wire logic eq_in_b,
    input wire logic cp_in_1a,
    input wire logic cp_in_1b,
    input wire logic cp_in_2a,
    input wire logic cp_in_2b,
    input wire logic [2:0] op_in,
    input wire logic [1:0] rel_in,
    input wire logic cyc_req,
    output logic eq_enable,
    output logic eq_disc_err,
    output logic eq_fault,
    output logic cp_enable,
    output logic cp_disc_err1,
    output logic cp_disc_err2,
    output logic cp_fault,
    output logic mo_enable,
    output logic irq
);
    // ----------------------------------------------------------------
    // registers and apb slave
    // ----------------------------------------------------------------
    logic [31:0] ctrl_reg;
    logic [31:0] disc_reg;
    logic [thmo_pkg::NEV-1:0] irq_reg;
    logic [thmo_pkg::NEV-1:0] mask_reg;
    logic [thmo_pkg::NEV-1:0] ev_set;
    logic acc;
    logic irq_rd;

    assign acc = psel && penable && pready;
    assign irq_rd = acc && !pwrite && paddr == thmo_pkg::ADDR_IRQ;

    // one wait state: pready rises in the second access cycle, drops after
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            pready <= 1'b0;
        else
            pready <= psel && penable && !pready;
    end

    // writes land only at the completing edge
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            ctrl_reg <= thmo_pkg::CTRL_RESET;
            disc_reg <= thmo_pkg::DISC_RESET;
            mask_reg <= '0;
        end
        else if (acc && pwrite)
        begin
            unique case (paddr)
                thmo_pkg::ADDR_CTRL: ctrl_reg <= pwdata & 32'h0000_03FF;
                thmo_pkg::ADDR_DISC: disc_reg <= pwdata & 32'h0000_3F3F;
                thmo_pkg::ADDR_MASK: mask_reg <= pwdata[thmo_pkg::NEV-1:0];
                default: ;
            endcase
        end
    end

    // read data and error for unmapped addresses
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            prdata <= '0;
            pslverr <= 1'b0;
        end
        else if (psel && penable && !pready)
        begin
            pslverr <= 1'b0;
            unique case (paddr)
                thmo_pkg::ADDR_CTRL: prdata <= ctrl_reg;
                thmo_pkg::ADDR_DISC: prdata <= disc_reg;
                thmo_pkg::ADDR_STAT: prdata <= {24'h0000_00, mo_enable, cp_enable,
                    eq_enable, cp_disc_err2, cp_disc_err1, eq_disc_err, 2'b00};
                // an event in the sampling cycle is reported before the clear
                thmo_pkg::ADDR_IRQ: prdata <= {28'h000_0000, irq_reg | ev_set};
                thmo_pkg::ADDR_MASK: prdata <= {28'h000_0000, mask_reg};
                default:
                begin
                    prdata <= '0;
                    pslverr <= 1'b1;
                end
            endcase
        end
    end

    // sticky events; a new event in the clearing read cycle survives
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            irq_reg <= '0;
        else
            irq_reg <= (irq_rd ? '0 : irq_reg) | ev_set;
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            irq <= 1'b0;
        else
            irq <= |(((irq_rd ? '0 : irq_reg) | ev_set) & mask_reg);
    end

    // ----------------------------------------------------------------
    // logic execution tick, 10 ms
    // ----------------------------------------------------------------
    logic [31:0] tick_cnt;
    logic tick;
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            tick_cnt <= '0;
        else if (tick_cnt == 32'(TICK_CYC - 1))
            tick_cnt <= '0;
        else
            tick_cnt <= tick_cnt + 32'h0000_0001;
    end
    assign tick = tick_cnt == 32'(TICK_CYC - 1);

    // inputs sampled once per logic cycle
    logic eq_a_s, eq_b_s, c1a_s, c1b_s, c2a_s, c2b_s, cyc_s, cyc_prev;
    logic [2:0] op_s;
    logic [1:0] rel_s;
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            {eq_a_s, eq_b_s, c1a_s, c1b_s, c2a_s, c2b_s, cyc_s} <= 7'h00;
            op_s <= '0;
            rel_s <= '0;
        end
        else if (tick)
        begin
            {eq_a_s, eq_b_s} <= {eq_in_a, eq_in_b};
            {c1a_s, c1b_s, c2a_s, c2b_s} <= {cp_in_1a, cp_in_1b, cp_in_2a, cp_in_2b};
            op_s <= op_in;
            rel_s <= rel_in;
            cyc_s <= cyc_req;
        end
    end

    // delayed tick: evaluation happens the cycle after sampling
    logic tick_d;
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            tick_d <= 1'b0;
        else
            tick_d <= tick;
    end

    // ----------------------------------------------------------------
    // equivalent-variant evaluator
    // ----------------------------------------------------------------
    logic [5:0] eq_tmr;
    logic eq_armed;
    logic eq_err_int;
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            eq_tmr <= '0;
            eq_armed <= 1'b0;
            eq_err_int <= 1'b0;
            eq_enable <= 1'b0;
        end
        else if (tick_d)
        begin
            if (!eq_a_s && !eq_b_s)
            begin
                // both off: ready for a new actuation
                eq_armed <= 1'b1;
                eq_tmr <= '0;
                eq_enable <= 1'b0;
            end
            else if (eq_a_s && eq_b_s)
            begin
                // both on: enable only after a clean sequence
                if (eq_armed && !eq_err_int)
                begin
                    eq_enable <= 1'b1;
                    eq_err_int <= 1'b0;
                end
                eq_armed <= 1'b0;
            end
            else
            begin
                // discrepant: fixed limit, enable drops at once
                eq_enable <= 1'b0;
                if (eq_tmr < 6'(thmo_pkg::LIMIT_TICKS))
                    eq_tmr <= eq_tmr + 6'h01;
                else if (eq_armed)
                    eq_err_int <= 1'b1;
            end
            if (!eq_a_s && !eq_b_s && eq_err_int)
                eq_err_int <= 1'b0;
        end
    end

    // optional error and fault outputs
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            eq_disc_err <= 1'b0;
            eq_fault <= 1'b0;
        end
        else
        begin
            eq_disc_err <= eq_err_int && ctrl_reg[thmo_pkg::CTRL_EQ_NOUT];
            eq_fault <= eq_err_int && ctrl_reg[thmo_pkg::CTRL_EQ_FLT];
        end
    end

    // ----------------------------------------------------------------
    // complementary-variant evaluator
    // ----------------------------------------------------------------
    logic p1_on, p1_off, p2_on, p2_off;
    assign p1_on = c1a_s && !c1b_s;
    assign p1_off = !c1a_s && c1b_s;
    assign p2_on = c2a_s && !c2b_s;
    assign p2_off = !c2a_s && c2b_s;

    logic [5:0] d1_tmr, d2_tmr, sync_tmr;
    logic cp_armed, sync_lost, cp_e1, cp_e2;
    logic [5:0] d1_lim, d2_lim;
    assign d1_lim = disc_reg[5:0];
    assign d2_lim = disc_reg[13:8];

    logic d1_hit, d2_hit, cp_hit, cp_clear;
    assign d1_hit = d1_lim != 6'h00 && !(p1_on || p1_off) && d1_tmr + 6'h01 >= d1_lim;
    assign d2_hit = d2_lim != 6'h00 && !(p2_on || p2_off) && d2_tmr + 6'h01 >= d2_lim;
    // errors of earlier actuations fall with the next clean enable, so they cannot lock it out
    assign cp_clear = !cp_enable && p1_on && p2_on && cp_armed && !sync_lost && !cp_hit;

    // per pair discrepancy timers, 0 disables
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            d1_tmr <= '0;
            d2_tmr <= '0;
            cp_e1 <= 1'b0;
            cp_e2 <= 1'b0;
            cp_hit <= 1'b0;
        end
        else if (tick_d)
        begin
            d1_tmr <= (p1_on || p1_off) ? 6'h00 : d1_tmr + 6'h01;
            d2_tmr <= (p2_on || p2_off) ? 6'h00 : d2_tmr + 6'h01;
            // a limit lapsed in this actuation blocks it until both pairs let go
            if (p1_off && p2_off)
                cp_hit <= 1'b0;
            else if (d1_hit || d2_hit)
                cp_hit <= 1'b1;
            if (d1_hit)
                cp_e1 <= 1'b1;
            else if (cp_clear)
                cp_e1 <= 1'b0;
            if (d2_hit)
                cp_e2 <= 1'b1;
            else if (cp_clear)
                cp_e2 <= 1'b0;
        end
    end

    // synchronization window; exceeding it only blocks this actuation
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            sync_tmr <= '0;
            cp_armed <= 1'b0;
            sync_lost <= 1'b0;
            cp_enable <= 1'b0;
        end
        else if (tick_d)
        begin
            if (p1_off && p2_off)
            begin
                // sync inactive only with both pairs released
                cp_armed <= 1'b1;
                sync_lost <= 1'b0;
                sync_tmr <= '0;
                cp_enable <= 1'b0;
            end
            else if (p1_on && p2_on && !cp_enable)
            begin
                if (cp_armed && !sync_lost && !cp_hit)
                    cp_enable <= 1'b1;
                cp_armed <= 1'b0;
            end
            else if (!(p1_on && p2_on))
            begin
                cp_enable <= 1'b0;
                if (sync_tmr < 6'(thmo_pkg::LIMIT_TICKS))
                    sync_tmr <= sync_tmr + 6'h01;
                else
                    sync_lost <= 1'b1;
            end
        end
    end

    // output selection: enable, + pair 1 error, + pair 2 error
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            cp_disc_err1 <= 1'b0;
            cp_disc_err2 <= 1'b0;
            cp_fault <= 1'b0;
        end
        else
        begin
            cp_disc_err1 <= cp_e1 && ctrl_reg[thmo_pkg::CTRL_CP_NOUT0 +: 2] != 2'b00;
            cp_disc_err2 <= cp_e2 && ctrl_reg[thmo_pkg::CTRL_CP_NOUT0 +: 2] >= 2'b10;
            cp_fault <= (cp_e1 || cp_e2) && ctrl_reg[thmo_pkg::CTRL_CP_FLT];
        end
    end

    // ----------------------------------------------------------------
    // multi-operator combiner
    // ----------------------------------------------------------------
    logic [2:0] op_mask;
    logic [1:0] rel_mask;
    logic [2:0] released;
    logic run_prev, rearm, cyc_edge, ops_hi, rels_hi;
    assign op_mask = ctrl_reg[thmo_pkg::CTRL_OPS3] ? 3'b111 : 3'b011;
    assign rel_mask = ctrl_reg[thmo_pkg::CTRL_NREL0 +: 2] == 2'b00 ? 2'b00 :
        ctrl_reg[thmo_pkg::CTRL_NREL0 +: 2] == 2'b01 ? 2'b01 : 2'b11;
    assign ops_hi = (op_s & op_mask) == op_mask;
    assign rels_hi = (rel_s & rel_mask) == rel_mask;
    assign cyc_edge = tick_d && (ctrl_reg[thmo_pkg::CTRL_CYC_FALL] ?
        (cyc_prev && !cyc_s) : (!cyc_prev && cyc_s));
    assign rearm = ctrl_reg[thmo_pkg::CTRL_RUN] && !run_prev;

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            run_prev <= 1'b0;
            cyc_prev <= 1'b0;
        end
        else
        begin
            run_prev <= ctrl_reg[thmo_pkg::CTRL_RUN];
            if (tick_d)
                cyc_prev <= cyc_s;
        end
    end

    // release-before-start memory, cleared on re-arm
    always_ff @(posedge clk_sys)
    begin
        if (srst || rearm || cyc_edge)
            released <= 3'b000;
        else if (tick_d)
            released <= released | ~op_s;
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst || rearm || cyc_edge || !ctrl_reg[thmo_pkg::CTRL_RUN])
            mo_enable <= 1'b0;
        else if (tick_d)
        begin
            if (!ops_hi || !rels_hi)
                mo_enable <= 1'b0;
            else if ((released & op_mask) == op_mask)
                mo_enable <= 1'b1;
        end
    end

    // error events are the rising edges of the error flags, so a clearing read is not undone
    logic [2:0] err_prev;
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            err_prev <= 3'b000;
        else
            err_prev <= {cp_e2, cp_e1, eq_err_int};
    end
    assign ev_set = {cyc_edge, {cp_e2, cp_e1, eq_err_int} & ~err_prev};

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_mo_drop: assert property (@(posedge clk_sys) disable iff (srst)
        tick_d && ctrl_reg[thmo_pkg::CTRL_RUN] && !ops_hi |=> !mo_enable)
        else $error("combiner enable stayed high with operator low");
    a_mo_rel: assert property (@(posedge clk_sys) disable iff (srst)
        tick_d && !rels_hi |=> !mo_enable)
        else $error("combiner enable high with release low");
    a_cyc_drop: assert property (@(posedge clk_sys) disable iff (srst)
        cyc_edge |=> !mo_enable && released == 3'b000)
        else $error("cycle edge did not drop enable");
    a_rearm_run: assert property (@(posedge clk_sys) disable iff (srst)
        rearm |=> released == 3'b000)
        else $error("stop to run did not re-arm");
    a_mo_rise: assert property (@(posedge clk_sys) disable iff (srst)
        $rose(mo_enable) |-> $past(released & op_mask) == op_mask)
        else $error("enable rose without release of all operators");
    a_eq_level: assert property (@(posedge clk_sys) disable iff (srst)
        eq_enable |-> $past(eq_a_s && eq_b_s))
        else $error("equivalent enable high with pair not high");
    a_eq_err_hide: assert property (@(posedge clk_sys) disable iff (srst)
        !ctrl_reg[thmo_pkg::CTRL_EQ_NOUT] ##1 !ctrl_reg[thmo_pkg::CTRL_EQ_NOUT]
        |-> !eq_disc_err)
        else $error("error output shown while disabled");
    a_cp_err2: assert property (@(posedge clk_sys) disable iff (srst)
        cp_disc_err2 |-> $past(ctrl_reg[thmo_pkg::CTRL_CP_NOUT0 +: 2]) >= 2'b10)
        else $error("pair 2 error shown with fewer outputs");
    a_cp_sync: assert property (@(posedge clk_sys) disable iff (srst)
        $rose(cp_enable) |-> $past(!sync_lost && cp_armed))
        else $error("complementary enable rose after window lapse");
    a_cp_opp: assert property (@(posedge clk_sys) disable iff (srst)
        $rose(cp_enable) |-> $past(p1_on && p2_on))
        else $error("complementary enable without opposite levels");
endmodule : thmo_top
